// >>> hw/clock_control_pkg.sv
package clock_control_pkg;

  // Register byte addresses on the AXI4-Lite port.
  localparam logic [7:0] ADDR_MODE_SELECT = 8'h00;
  localparam logic [7:0] ADDR_INT_OSC_MODE = 8'h04;
  localparam logic [7:0] ADDR_MAIN_OSC_CTRL = 8'h08;
  localparam logic [7:0] ADDR_PROC_CLK_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_STAB_SELECT = 8'h10;
  localparam logic [7:0] ADDR_STAB_STATUS = 8'h14;

  // Field positions.
  localparam int SELECT_BIT = 0;
  localparam int SOURCE_STATUS_BIT = 1;
  localparam int INT_STOP_BIT = 0;
  localparam int MAIN_STOP_BIT = 7;
  localparam int SUB_SELECT_BIT = 4;
  localparam int SUB_STATUS_BIT = 5;
  localparam int MAIN_STOP_SUB_BIT = 7;
  localparam int STAB_SELECT_LSB = 0;
  localparam int STAB_STATUS_LSB = 0;

  // Reset values.
  localparam logic SELECT_RST = 1'b0;
  localparam logic INT_STOP_RST = 1'b0;
  localparam logic MAIN_STOP_RST = 1'b0;
  localparam logic SUB_SELECT_RST = 1'b0;
  localparam logic MAIN_STOP_SUB_RST = 1'b0;
  localparam logic [2:0] STAB_SELECT_RST = 3'h5;

  // Timing counts, in oscillator cycles.
  localparam logic [4:0] HOLD_TICKS = 5'h11;
  localparam logic [1:0] SWITCH_TICKS = 2'h2;
  localparam int STAB_CHOICES = 5;
  localparam logic [16:0] STAB_CYCLES [STAB_CHOICES] = '{
    17'h00800, 17'h02000, 17'h04000, 17'h08000, 17'h10000
  };

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {MODE_HOLD, MODE_RUN, MODE_HALT, MODE_STOP, MODE_STAB} mode_e;
  typedef enum logic [1:0] {SRC_INT, SRC_MAIN, SRC_SUB} src_e;

  typedef struct packed {
    mode_e mode;
    src_e src;
    logic sel;
    logic int_stop;
    logic main_stop;
    logic sub_sel;
    logic main_stop_sub;
    logic [2:0] stab_sel;
    logic [4:0] hold_cnt;
    logic [1:0] sw_cnt;
    logic [16:0] stab_cnt;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

endpackage : clock_control_pkg

// >>> hw/cpu_clock_start_and_mode_control.sv
`timescale 1ns/10ps
module cpu_clock_start_and_mode_control
  import clock_control_pkg::*;
#(
  parameter logic INT_OSC_STOPPABLE = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_reset,
  input wire logic power_on_clear,
  input wire logic low_voltage_detector,
  input wire logic clock_monitor_reset,
  input wire logic watchdog_overflow,
  input wire logic int_osc_tick,
  input wire logic main_osc_tick,
  input wire logic sub_osc_tick,
  input wire logic halt_req,
  input wire logic stop_req,
  input wire logic wake_req,
  output logic internal_reset,
  output logic int_osc_run,
  output logic main_osc_run,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic watchdog_clk_en,
  output logic cpu_on_main,
  output logic cpu_on_sub,
  output logic cpu_halted,
  output logic cpu_stopped
);

  state_s s_r;
  state_s s_nxt;
  logic rst_any;
  logic [STAB_CHOICES-1:0] stab_reached;
  logic cur_tick;
  logic src_tgt_run;
  src_e tgt;
  logic [2:0] stab_idx;

  // Any reset source, including the watchdog overflow, restarts the controller.
  assign rst_any = ~aresetn | ext_reset | power_on_clear | low_voltage_detector |
                   clock_monitor_reset | watchdog_overflow;
  assign internal_reset = rst_any;

  // Oscillator run controls; both stop in reset, otherwise the CPU source is never stopped under it, except the main oscillator in STOP mode.
  always_comb begin
    if (rst_any) begin
      int_osc_run = 1'b0;
      main_osc_run = 1'b0;
    end else begin
      int_osc_run = ~(INT_OSC_STOPPABLE & s_r.int_stop & (s_r.src != SRC_INT));
      if (s_r.mode == MODE_STOP || s_r.mode == MODE_STAB && s_r.stab_cnt == 17'h00000) begin
        main_osc_run = s_r.mode == MODE_STAB;
      end else if (s_r.src == SRC_MAIN) begin
        main_osc_run = 1'b1;
      end else if (s_r.src == SRC_SUB) begin
        main_osc_run = ~s_r.main_stop_sub;
      end else begin
        main_osc_run = ~s_r.main_stop;
      end
    end
  end

  // Tick of the clock the CPU is on now; the source software asks for, and whether it runs.
  always_comb begin
    unique case (s_r.src)
      SRC_INT: cur_tick = int_osc_tick & int_osc_run;
      SRC_MAIN: cur_tick = main_osc_tick & main_osc_run;
      SRC_SUB: cur_tick = sub_osc_tick;
      default: cur_tick = 1'b0; // The unused code passes no pulse.
    endcase
    if (s_r.sub_sel) begin
      tgt = SRC_SUB;
    end else if (s_r.sel) begin
      tgt = SRC_MAIN;
    end else begin
      tgt = SRC_INT;
    end
    unique case (tgt)
      SRC_INT: src_tgt_run = int_osc_run;
      SRC_MAIN: src_tgt_run = main_osc_run;
      SRC_SUB: src_tgt_run = 1'b1;
      default: src_tgt_run = 1'b0;
    endcase
  end

  // Stabilization thresholds, one comparator per selectable time.
  for (genvar i = 0; i < STAB_CHOICES; i++) begin : g_stab
    assign stab_reached[i] = s_r.stab_cnt >= STAB_CYCLES[i];
  end

  // Codes 1 to 5 pick a threshold; a prohibited code falls back to the longest wait.
  always_comb begin
    if (s_r.stab_sel >= 3'h1 && s_r.stab_sel <= 3'h5) begin
      stab_idx = s_r.stab_sel - 3'h1;
    end else begin
      stab_idx = 3'h4;
    end
  end

  // Next state: clock control, bus slave and the reset overlay.
  always_comb begin
    s_nxt = s_r;
    // Counts main oscillator cycles since it started; saturates at the longest wait.
    if (!main_osc_run) begin
      s_nxt.stab_cnt = 17'h00000;
    end else if (main_osc_tick && !stab_reached[STAB_CHOICES-1]) begin
      s_nxt.stab_cnt = s_r.stab_cnt + 17'h00001;
    end

    unique case (s_r.mode)
      MODE_HOLD: begin
        if (int_osc_tick && int_osc_run) begin
          if (s_r.hold_cnt == HOLD_TICKS - 5'h01) begin
            s_nxt.mode = MODE_RUN;
          end else begin
            s_nxt.hold_cnt = s_r.hold_cnt + 5'h01;
          end
        end
      end
      MODE_RUN: begin
        if (stop_req && s_r.src != SRC_SUB) begin
          s_nxt.mode = MODE_STOP;
        end else if (halt_req) begin
          s_nxt.mode = MODE_HALT;
        end
        // A pending change waits for whole cycles of the old clock, so no phase is cut.
        if (tgt != s_r.src && src_tgt_run &&
            !(tgt == SRC_SUB && s_r.src == SRC_INT) &&
            !(tgt == SRC_INT && s_r.src == SRC_SUB)) begin
          if (cur_tick) begin
            if (s_r.sw_cnt == SWITCH_TICKS - 2'h1) begin
              s_nxt.src = tgt;
              s_nxt.sw_cnt = 2'h0;
            end else begin
              s_nxt.sw_cnt = s_r.sw_cnt + 2'h1;
            end
          end
        end else begin
          s_nxt.sw_cnt = 2'h0;
        end
      end
      MODE_HALT: begin
        if (wake_req) begin
          s_nxt.mode = MODE_RUN;
        end
      end
      MODE_STOP: begin
        if (wake_req) begin
          s_nxt.mode = (s_r.src == SRC_MAIN) ? MODE_STAB : MODE_RUN;
        end
      end
      MODE_STAB: begin
        if (stab_reached[stab_idx]) begin
          s_nxt.mode = MODE_RUN;
        end
      end
      default: s_nxt.mode = MODE_HOLD;
    endcase

    // Write channel: address and data are caught in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (s_r.aw_held && s_r.w_held) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      unique case (s_r.aw_addr)
        ADDR_MODE_SELECT: begin
          if (s_r.w_lane0) begin
            s_nxt.sel = s_r.w_data[SELECT_BIT];
          end
        end
        ADDR_INT_OSC_MODE: begin
          if (s_r.w_lane0) begin
            s_nxt.int_stop = s_r.w_data[INT_STOP_BIT];
          end
        end
        ADDR_MAIN_OSC_CTRL: begin
          if (s_r.w_lane0) begin
            s_nxt.main_stop = s_r.w_data[MAIN_STOP_BIT];
          end
        end
        ADDR_PROC_CLK_CTRL: begin
          if (s_r.w_lane0) begin
            s_nxt.sub_sel = s_r.w_data[SUB_SELECT_BIT];
            s_nxt.main_stop_sub = s_r.w_data[MAIN_STOP_SUB_BIT];
          end
        end
        ADDR_STAB_SELECT: begin
          if (s_r.w_lane0) begin
            s_nxt.stab_sel = s_r.w_data[STAB_SELECT_LSB +: 3];
          end
        end
        ADDR_STAB_STATUS: begin
          // Read-only; the write is accepted and dropped.
        end
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Read channel: data is latched at the address handshake.
    if (s_axi_arvalid && s_axi_arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h00000000;
      unique case (s_axi_araddr)
        ADDR_MODE_SELECT: begin
          s_nxt.rdata[SELECT_BIT] = s_r.sel;
          s_nxt.rdata[SOURCE_STATUS_BIT] = s_r.src == SRC_MAIN;
        end
        ADDR_INT_OSC_MODE: s_nxt.rdata[INT_STOP_BIT] = s_r.int_stop;
        ADDR_MAIN_OSC_CTRL: s_nxt.rdata[MAIN_STOP_BIT] = s_r.main_stop;
        ADDR_PROC_CLK_CTRL: begin
          s_nxt.rdata[SUB_SELECT_BIT] = s_r.sub_sel;
          s_nxt.rdata[SUB_STATUS_BIT] = s_r.src == SRC_SUB;
          s_nxt.rdata[MAIN_STOP_SUB_BIT] = s_r.main_stop_sub;
        end
        ADDR_STAB_SELECT: s_nxt.rdata[STAB_SELECT_LSB +: 3] = s_r.stab_sel;
        ADDR_STAB_STATUS: s_nxt.rdata[STAB_STATUS_LSB +: STAB_CHOICES] = stab_reached;
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // Any reset source overrides the clock controller fields; the bus keeps its own state unless aresetn is low.
    if (rst_any) begin
      s_nxt.mode = MODE_HOLD;
      s_nxt.src = SRC_INT;
      s_nxt.sel = SELECT_RST;
      s_nxt.int_stop = INT_STOP_RST;
      s_nxt.main_stop = MAIN_STOP_RST;
      s_nxt.sub_sel = SUB_SELECT_RST;
      s_nxt.main_stop_sub = MAIN_STOP_SUB_RST;
      s_nxt.stab_sel = STAB_SELECT_RST;
      s_nxt.hold_cnt = 5'h00;
      s_nxt.sw_cnt = 2'h0;
      s_nxt.stab_cnt = 17'h00000;
    end
  end

  // State register; the bus reset clears the handshake flags too.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '{
        mode: MODE_HOLD,
        src: SRC_INT,
        sel: SELECT_RST,
        int_stop: INT_STOP_RST,
        main_stop: MAIN_STOP_RST,
        sub_sel: SUB_SELECT_RST,
        main_stop_sub: MAIN_STOP_SUB_RST,
        stab_sel: STAB_SELECT_RST,
        bresp: RESP_OKAY,
        rresp: RESP_OKAY,
        default: '0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // Bus handshakes: one write and one read in flight, each held until answered.
  assign s_axi_awready = ~s_r.aw_held & ~s_r.bvalid;
  assign s_axi_wready = ~s_r.w_held & ~s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = ~s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  // Clock enables are whole oscillator ticks, so a switch cannot shorten a phase.
  assign cpu_clk_en = ~rst_any & (s_r.mode == MODE_RUN) & cur_tick;
  // The prescaler runs in RUN and HALT on the clock the select bit names.
  assign periph_clk_en = ~rst_any & (s_r.mode == MODE_RUN || s_r.mode == MODE_HALT) &
                         (s_r.sel ? (main_osc_tick & main_osc_run)
                                  : (int_osc_tick & int_osc_run));
  // Stoppable option gates the watchdog in standby; otherwise it counts through STOP.
  assign watchdog_clk_en = ~rst_any & int_osc_tick & int_osc_run &
                           (~INT_OSC_STOPPABLE |
                            (s_r.mode != MODE_HALT && s_r.mode != MODE_STOP &&
                             s_r.mode != MODE_STAB));
  assign cpu_on_main = s_r.src == SRC_MAIN;
  assign cpu_on_sub = s_r.src == SRC_SUB;
  assign cpu_halted = s_r.mode == MODE_HALT;
  assign cpu_stopped = s_r.mode == MODE_STOP || s_r.mode == MODE_STAB;

endmodule : cpu_clock_start_and_mode_control

// >>> verif/clock_control_monitor.sv
`timescale 1ns/10ps
// Watches the controller's pins; the tick counter mirrors the start-up hold.
module clock_control_monitor #(
  parameter logic INT_OSC_STOPPABLE = 1'h1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_reset,
  input wire logic power_on_clear,
  input wire logic low_voltage_detector,
  input wire logic clock_monitor_reset,
  input wire logic watchdog_overflow,
  input wire logic int_osc_tick,
  input wire logic main_osc_tick,
  input wire logic sub_osc_tick,
  input wire logic internal_reset,
  input wire logic int_osc_run,
  input wire logic main_osc_run,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic watchdog_clk_en,
  input wire logic cpu_on_main,
  input wire logic cpu_on_sub,
  input wire logic cpu_halted,
  input wire logic cpu_stopped
);
  logic [4:0] hold_n;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Saturates so that a long run never wraps back under the hold count.
  always_ff @(posedge aclk) begin
    if (internal_reset) begin
      hold_n <= 5'h00;
    end else if (int_osc_tick && hold_n != 5'h1F) begin
      hold_n <= hold_n + 5'h01;
    end
  end

  // Moves between subsystem and internal clock that skip the main oscillator.
  sequence int_to_sub;
    !cpu_on_main && !cpu_on_sub ##1 cpu_on_sub;
  endsequence
  sequence sub_to_int;
    cpu_on_sub && !internal_reset ##1 !cpu_on_sub && !cpu_on_main;
  endsequence

  a_reset_osc_off: assert property (internal_reset |-> !int_osc_run && !main_osc_run)
    else $error("oscillator runs in reset");
  a_reset_any_source: assert property ((ext_reset || power_on_clear ||
    low_voltage_detector || clock_monitor_reset || watchdog_overflow) |-> internal_reset)
    else $error("reset source ignored");
  a_reset_to_int: assert property (internal_reset |=> !cpu_on_main && !cpu_on_sub)
    else $error("source not internal after reset");
  a_hold_count: assert property (cpu_clk_en |-> hold_n >= 5'h11)
    else $error("cpu clock before hold ends");
  a_cpu_en_source: assert property (cpu_clk_en |->
    (cpu_on_sub ? sub_osc_tick : cpu_on_main ? main_osc_tick : int_osc_tick))
    else $error("cpu pulse from wrong source");
  a_stop_gates: assert property (cpu_stopped |-> !cpu_clk_en && !periph_clk_en)
    else $error("clock pulse in stop");
  a_halt_prescaler: assert property (cpu_halted && !cpu_on_sub |-> !cpu_clk_en &&
    periph_clk_en == (cpu_on_main ? main_osc_tick : int_osc_tick))
    else $error("prescaler source wrong in halt");
  a_wdt_standby: assert property (INT_OSC_STOPPABLE &&
    (cpu_halted || cpu_stopped) |-> !watchdog_clk_en)
    else $error("watchdog clocked in standby");
  a_sub_no_stop: assert property (cpu_on_sub && !cpu_stopped |=> !cpu_stopped)
    else $error("stop entered on subsystem clock");
  a_sub_int_direct: assert property (not (int_to_sub or sub_to_int))
    else $error("direct subsystem and internal switch");
endmodule : clock_control_monitor

bind cpu_clock_start_and_mode_control clock_control_monitor #(
  .INT_OSC_STOPPABLE(INT_OSC_STOPPABLE)
) i_clock_control_monitor (
  .aclk, .aresetn, .ext_reset, .power_on_clear, .low_voltage_detector,
  .clock_monitor_reset, .watchdog_overflow, .int_osc_tick, .main_osc_tick,
  .sub_osc_tick, .internal_reset, .int_osc_run, .main_osc_run, .cpu_clk_en,
  .periph_clk_en, .watchdog_clk_en, .cpu_on_main, .cpu_on_sub, .cpu_halted,
  .cpu_stopped
);

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb;
  import clock_control_pkg::*;
  // Inputs start quiet; protection and strobes stay fixed.
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic ext_reset = 1'h0, power_on_clear = 1'h0, low_voltage_detector = 1'h0;
  logic clock_monitor_reset = 1'h0, watchdog_overflow = 1'h0;
  logic int_osc_tick = 1'h0, main_osc_tick = 1'h0, sub_osc_tick = 1'h0;
  logic halt_req = 1'h0, stop_req = 1'h0, wake_req = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd, n_cpu, n_per, n_wdt;
  logic internal_reset, int_osc_run, main_osc_run, cpu_clk_en, periph_clk_en;
  logic watchdog_clk_en, cpu_on_main, cpu_on_sub, cpu_halted, cpu_stopped;
  int fails = 0, n_checks = 0, exp_sel = 0, exp_main = 0;

  cpu_clock_start_and_mode_control #(.INT_OSC_STOPPABLE(1'h1))
    i_cpu_clock_start_and_mode_control (.*);

  // Free-running 100 MHz clock.
  always #5 aclk = ~aclk;

  task automatic finish_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : check

  // A bus wait that runs out ends the run rather than hanging it.
  task automatic guard(input int k);
    if (k > 40) begin
      fails++;
      finish_test();
    end
  endtask : guard

  // Handshakes are judged just before the edge that completes them.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    logic ta, tw, tb;
    k = 0;
    tb = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (tb !== 1'h1) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
      k++;
      guard(k);
    end
    check("bresp", {30'h0, er}, {30'h0, rs});
    // Callers then look at settled outputs, not at the edge that launches them.
    @(negedge aclk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int k;
    logic ta, tr;
    k = 0;
    tr = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (tr !== 1'h1) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
      k++;
      guard(k);
    end
    check("rdata", e, rd);
    check("rresp", {30'h0, er}, {30'h0, rs});
  endtask : rd_chk

  // One oscillator tick is one high cycle then one low; enables are counted mid-cycle.
  task automatic pulse(input int k, input int n);
    n_cpu = 32'h0;
    n_per = 32'h0;
    n_wdt = 32'h0;
    repeat (n) begin
      @(posedge aclk);
      {int_osc_tick, main_osc_tick, sub_osc_tick} <= 3'h4 >> k;
      @(negedge aclk);
      n_cpu += cpu_clk_en;
      n_per += periph_clk_en;
      n_wdt += watchdog_clk_en;
      @(posedge aclk);
      {int_osc_tick, main_osc_tick, sub_osc_tick} <= 3'h0;
    end
    @(negedge aclk);
  endtask : pulse

  // Halt, stop or wake request for a single cycle.
  task automatic req(input int k);
    @(posedge aclk);
    {halt_req, stop_req, wake_req} <= 3'h4 >> k;
    @(posedge aclk);
    {halt_req, stop_req, wake_req} <= 3'h0;
    @(negedge aclk);
  endtask : req

  // Main sequence; the expected mode word comes from exp_sel and exp_main.
  initial begin
    void'($urandom(10));
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    check("osc run", 32'h0, {30'h0, int_osc_run, main_osc_run});
    @(posedge aclk);
    aresetn <= 1'h1;
    pulse(0, 17);
    check("hold", 32'h0, n_cpu);
    pulse(0, 1);
    check("first", 32'h1, n_cpu);
    check("run wdt", 32'h1, n_wdt);
    rd_chk(ADDR_MODE_SELECT, 32'(exp_main * 2 + exp_sel), RESP_OKAY);
    rd_chk(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    rd_chk(ADDR_STAB_SELECT, 32'(STAB_SELECT_RST), RESP_OKAY);
    // Status read 0 above, so software may stop and restart the main oscillator.
    wr(ADDR_MAIN_OSC_CTRL, 32'h80, RESP_OKAY);
    check("main stop", 32'h0, {31'h0, main_osc_run});
    rd_chk(ADDR_MAIN_OSC_CTRL, 32'h80, RESP_OKAY);
    wr(ADDR_MAIN_OSC_CTRL, 32'h0, RESP_OKAY);
    check("main start", 32'h1, {31'h0, main_osc_run});
    pulse(1, 2100);
    rd_chk(ADDR_STAB_STATUS, 32'h1, RESP_OKAY);
    exp_sel = 1;
    wr(ADDR_MODE_SELECT, ($urandom() & 32'hFFFFFF00) | 32'h1, RESP_OKAY);
    rd_chk(ADDR_MODE_SELECT, 32'(exp_main * 2 + exp_sel), RESP_OKAY);
    pulse(0, 1);
    check("on main", 32'h0, {31'h0, cpu_on_main});
    pulse(0, 1);
    exp_main = 1;
    rd_chk(ADDR_MODE_SELECT, 32'(exp_main * 2 + exp_sel), RESP_OKAY);
    wr(ADDR_INT_OSC_MODE, 32'h1, RESP_OKAY);
    check("int off", 32'h0, {31'h0, int_osc_run});
    rd_chk(ADDR_INT_OSC_MODE, 32'h1, RESP_OKAY);
    wr(ADDR_INT_OSC_MODE, 32'h0, RESP_OKAY);
    req(0);
    check("halted", 32'h1, {31'h0, cpu_halted});
    pulse(1, 4);
    check("halt per", 32'h4, n_per + n_cpu);
    pulse(0, 4);
    check("halt wdt", 32'h0, n_wdt);
    check("int on", 32'h1, {31'h0, int_osc_run});
    req(2);
    pulse(1, 2);
    check("resume", 32'h2, n_cpu);
    wr(ADDR_STAB_SELECT, 32'h1, RESP_OKAY);
    req(1);
    check("stopped", 32'h1, {31'h0, cpu_stopped});
    req(2);
    pulse(1, 2040);
    check("stab wait", 32'h0, n_cpu);
    pulse(1, 20);
    check("stab done", 32'h0C, n_cpu);
    wr(ADDR_PROC_CLK_CTRL, 32'h10, RESP_OKAY);
    pulse(1, 2);
    rd_chk(ADDR_PROC_CLK_CTRL, 32'h30, RESP_OKAY);
    req(1);
    check("sub stop", 32'h0, {31'h0, cpu_stopped});
    wr(ADDR_MAIN_OSC_CTRL, 32'h80, RESP_OKAY);
    check("main on", 32'h1, {31'h0, main_osc_run});
    wr(ADDR_PROC_CLK_CTRL, 32'h90, RESP_OKAY);
    check("main off", 32'h0, {31'h0, main_osc_run});
    req(0);
    pulse(0, 3);
    check("sub wdt", 32'h0, n_wdt);
    req(2);
    // Each reset input other than aresetn, on its own, must bring the select back to internal.
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_MODE_SELECT, 32'h1, RESP_OKAY);
      @(posedge aclk);
      {ext_reset, power_on_clear, low_voltage_detector, clock_monitor_reset,
        watchdog_overflow} <= 5'h10 >> i;
      @(posedge aclk);
      {ext_reset, power_on_clear, low_voltage_detector, clock_monitor_reset,
        watchdog_overflow} <= 5'h00;
      rd_chk(ADDR_MODE_SELECT, 32'h0, RESP_OKAY);
    end
    finish_test();
  end
endmodule : tb
